// file: verilog/rfsp_sector_guard.v
// per-sector guard bytes, password checks and rf access decisions
`default_nettype none
module rfsp_sector_guard (
  input  wire        core_clk,
  input  wire        reset_n,
  input  wire        rf_cmd_valid,
  output wire        rf_cmd_ready,
  input  wire [2:0]  rf_cmd_code,
  input  wire [3:0]  rf_sector,
  input  wire [1:0]  rf_pwd_sel,
  input  wire [31:0] rf_data,
  input  wire [3:0]  rf_guard_bits,
  input  wire        rf_opt_flag,
  output reg         rf_rsp_valid_q,
  output reg         rf_rsp_ok_q,
  output reg         rf_rsp_error_q,
  output reg         rf_rsp_guard_valid_q,
  output reg  [7:0]  rf_rsp_guard_q,
  output reg  [31:0] rf_rsp_data_q,
  output reg  [1:0]  rf_presented_q,
  input  wire        ser_valid,
  input  wire        ser_write,
  input  wire        upper_area_select,
  input  wire [3:0]  ser_addr,
  input  wire [3:0]  ser_be,
  input  wire [31:0] ser_wdata,
  input  wire        ser_pwd_ok,
  output reg         ser_rsp_valid_q,
  output reg         ser_rsp_error_q,
  output reg  [31:0] ser_rdata_q
);
`include "rfsp_defines.vh"

  localparam [1:0] ST_IDLE    = 2'h0;
  localparam [1:0] ST_PRESENT = 2'h1;
  localparam [1:0] ST_PRDATA  = 2'h2;

  reg  [1:0]   state_q;
  reg  [1:0]   state_d;
  reg  [1:0]   sel_q;
  reg  [31:0]  cand_q;
  reg          opt_q;
  wire [127:0] guard_flat;
  wire         rf_take;
  wire [7:0]   sel_guard;
  wire         sel_lock;
  wire [1:0]   sel_code;
  wire [1:0]   sel_link;
  wire         sel_linked;
  reg          rd_allow;
  reg          wr_allow;
  wire         ser_addr_ok;
  wire         ser_wr_go;
  wire         lock_go;
  wire         pwd_wr_go;
  wire [31:0]  pwd_rd;
  wire         sel_granted;

  assign rf_cmd_ready = (state_q == ST_IDLE) && !ser_valid;
  assign rf_take      = rf_cmd_valid && rf_cmd_ready;

  // serial access needs the upper area select and a word-aligned address
  assign ser_addr_ok = upper_area_select && (ser_addr[1:0] == 2'h0);
  assign ser_wr_go   = ser_valid && ser_write && ser_addr_ok
                       && ser_pwd_ok;

  // decode of the addressed sector's guard byte
  assign sel_guard  = guard_flat[rf_sector*8 +: 8];
  assign sel_lock   = sel_guard[`RFSP_LOCK_BIT];
  assign sel_code   = sel_guard[`RFSP_CODE_LSB +: 2];
  assign sel_link   = sel_guard[`RFSP_LINK_LSB +: 2];
  assign sel_linked = (sel_link != `RFSP_PWD_NONE)
                      && (sel_link == rf_presented_q);

  always @* begin
    rd_allow = 1'b1;
    wr_allow = 1'b1;
    if (sel_lock) begin
      case (sel_code)
        `RFSP_CODE_RD_FREE: begin
          rd_allow = 1'b1;
          wr_allow = sel_linked;
        end
        `RFSP_CODE_RW_FREE: begin
          rd_allow = 1'b1;
          wr_allow = 1'b1;
        end
        `RFSP_CODE_RW_PWD: begin
          rd_allow = sel_linked;
          wr_allow = sel_linked;
        end
        `RFSP_CODE_RD_PWD: begin
          rd_allow = sel_linked;
          wr_allow = 1'b0;
        end
        default: begin
          rd_allow = 1'b0;
          wr_allow = 1'b0;
        end
      endcase
    end
  end

  assign lock_go = rf_take && (rf_cmd_code == `RFSP_CMD_LOCK)
                   && !sel_lock;

  // a password block is reachable only once that password is presented
  assign sel_granted = (rf_pwd_sel != `RFSP_PWD_NONE)
                       && (rf_pwd_sel == rf_presented_q);
  assign pwd_wr_go   = rf_take && (rf_cmd_code == `RFSP_CMD_PWD_WRITE)
                       && sel_granted;

  // guard byte storage, one byte per sector
  genvar s;
  generate
    for (s = 0; s < 16; s = s + 1) begin : g_sector
      reg [7:0] guard_q;
      always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
          guard_q <= `RFSP_GUARD_RESET;
        end else if (ser_wr_go && ser_addr[3:2] == s / 4
                     && ser_be[s % 4]) begin
          // written value governs rf access from the next cycle
          guard_q <= {3'h0, ser_wdata[(s % 4)*8 +: 5]};
        end else if (lock_go && rf_sector == s) begin
          guard_q <= {3'h0, rf_guard_bits, 1'b1};
        end
      end
      assign guard_flat[s*8 +: 8] = guard_q;
    end
  endgenerate

  rfsp_pwd_mem u_pwd_mem (
    .core_clk  (core_clk),
    .reset_n   (reset_n),
    .wr_en     (pwd_wr_go),
    .wr_addr   (rf_pwd_sel),
    .wr_data   (rf_data),
    .rd_addr   (rf_pwd_sel),
    .rd_data_q (pwd_rd)
  );

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (rf_take && rf_pwd_sel != `RFSP_PWD_NONE) begin
          if (rf_cmd_code == `RFSP_CMD_PWD_PRESENT) begin
            state_d = ST_PRESENT;
          end else if (rf_cmd_code == `RFSP_CMD_PWD_READ
                       && sel_granted) begin
            state_d = ST_PRDATA;
          end
        end
      end
      ST_PRESENT: state_d = ST_IDLE;
      ST_PRDATA:  state_d = ST_IDLE;
      default:    state_d = ST_IDLE;
    endcase
  end

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
      sel_q   <= `RFSP_PWD_NONE;
      cand_q  <= `RFSP_PWD_RESET;
      opt_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      if (rf_take) begin
        sel_q  <= rf_pwd_sel;
        cand_q <= rf_data;
        opt_q  <= rf_opt_flag;
      end
    end
  end

  // rf answers and presented password
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rf_rsp_valid_q       <= 1'b0;
      rf_rsp_ok_q          <= 1'b0;
      rf_rsp_error_q       <= 1'b0;
      rf_rsp_guard_valid_q <= 1'b0;
      rf_rsp_guard_q       <= 8'h00;
      rf_rsp_data_q        <= 32'h00000000;
      rf_presented_q       <= `RFSP_PWD_NONE;
    end else begin
      rf_rsp_valid_q       <= 1'b0;
      rf_rsp_ok_q          <= 1'b0;
      rf_rsp_error_q       <= 1'b0;
      rf_rsp_guard_valid_q <= 1'b0;
      if (state_q == ST_PRESENT) begin
        rf_rsp_valid_q <= 1'b1;
        if (pwd_rd == cand_q) begin
          rf_presented_q <= sel_q;
          rf_rsp_ok_q    <= 1'b1;
        end else begin
          rf_presented_q <= `RFSP_PWD_NONE;
          rf_rsp_error_q <= 1'b1;
        end
      end else if (state_q == ST_PRDATA) begin
        rf_rsp_valid_q <= 1'b1;
        rf_rsp_ok_q    <= 1'b1;
        rf_rsp_data_q  <= pwd_rd;
      end else if (rf_take && state_d == ST_IDLE) begin
        rf_rsp_valid_q <= 1'b1;
        case (rf_cmd_code)
          `RFSP_CMD_READ: begin
            rf_rsp_ok_q          <= rd_allow;
            rf_rsp_error_q       <= !rd_allow;
            rf_rsp_guard_valid_q <= rf_opt_flag;
            rf_rsp_guard_q       <= sel_guard;
          end
          `RFSP_CMD_WRITE: begin
            rf_rsp_ok_q    <= wr_allow;
            rf_rsp_error_q <= !wr_allow;
          end
          `RFSP_CMD_LOCK: begin
            rf_rsp_ok_q    <= !sel_lock;
            rf_rsp_error_q <= sel_lock;
          end
          `RFSP_CMD_PWD_WRITE: begin
            rf_rsp_ok_q    <= sel_granted;
            rf_rsp_error_q <= !sel_granted;
          end
          default: begin
            rf_rsp_error_q <= 1'b1;
          end
        endcase
      end
    end
  end

  // serial answers, reads allowed without ser_pwd_ok
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ser_rsp_valid_q <= 1'b0;
      ser_rsp_error_q <= 1'b0;
      ser_rdata_q     <= 32'h00000000;
    end else begin
      ser_rsp_valid_q <= ser_valid;
      ser_rsp_error_q <= ser_valid && (!ser_addr_ok
                         || (ser_write && !ser_pwd_ok));
      if (ser_valid && !ser_write && ser_addr_ok) begin
        ser_rdata_q <= guard_flat[ser_addr[3:2]*32 +: 32];
      end
    end
  end
endmodule // rfsp_sector_guard
`default_nettype wire

// file: verilog/rfsp_defines.vh
// constants of the sector password protection block
`ifndef RFSP_DEFINES_VH
`define RFSP_DEFINES_VH
// serial byte offsets of the sector guard byte words
`define RFSP_OFS_GUARD_0_3     4'h0
`define RFSP_OFS_GUARD_4_7     4'h4
`define RFSP_OFS_GUARD_8_11    4'h8
`define RFSP_OFS_GUARD_12_15   4'hc
// password area block addresses
`define RFSP_PWD_NONE          2'h0
`define RFSP_PWD_ONE           2'h1
`define RFSP_PWD_TWO           2'h2
`define RFSP_PWD_THREE         2'h3
// guard byte field positions
`define RFSP_LOCK_BIT          0
`define RFSP_CODE_LSB          1
`define RFSP_LINK_LSB          3
`define RFSP_ZERO_LSB          5
// reset values
`define RFSP_GUARD_RESET       8'h00
`define RFSP_PWD_RESET         32'h00000000
// protection codes
`define RFSP_CODE_RD_FREE      2'h0
`define RFSP_CODE_RW_FREE      2'h1
`define RFSP_CODE_RW_PWD       2'h2
`define RFSP_CODE_RD_PWD       2'h3
// rf command codes
`define RFSP_CMD_READ          3'h0
`define RFSP_CMD_WRITE         3'h1
`define RFSP_CMD_LOCK          3'h2
`define RFSP_CMD_PWD_WRITE     3'h3
`define RFSP_CMD_PWD_PRESENT   3'h4
`define RFSP_CMD_PWD_READ      3'h5
`endif

// file: verilog/rfsp_pwd_mem.v
// four-word password store, word 0 never written, with registered read data
`default_nettype none
module rfsp_pwd_mem (
  input  wire        core_clk,
  input  wire        reset_n,
  input  wire        wr_en,
  input  wire [1:0]  wr_addr,
  input  wire [31:0] wr_data,
  input  wire [1:0]  rd_addr,
  output reg  [31:0] rd_data_q
);
`include "rfsp_defines.vh"

  wire [127:0] word_flat;

  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_word
      localparam [1:0] IDX = i;
      reg [31:0] word_q;
      always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
          word_q <= `RFSP_PWD_RESET;
        end else if (wr_en && wr_addr == IDX && IDX != 2'h0) begin
          word_q <= wr_data;
        end
      end
      assign word_flat[i*32 +: 32] = word_q;
    end
  endgenerate

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data_q <= `RFSP_PWD_RESET;
    end else begin
      rd_data_q <= word_flat[rd_addr*32 +: 32];
    end
  end
endmodule // rfsp_pwd_mem
`default_nettype wire

// file: tb/rfsp_guard_properties.sv
// assertions on the sector guard ports
`default_nettype none
`include "rfsp_defines.vh"
module rfsp_guard_properties (
  input wire logic       core_clk,
  input wire logic       reset_n,
  input wire logic       rf_cmd_valid,
  input wire logic       rf_cmd_ready,
  input wire logic [2:0] rf_cmd_code,
  input wire logic [1:0] rf_pwd_sel,
  input wire logic       rf_opt_flag,
  input wire logic       rf_rsp_valid_q,
  input wire logic       rf_rsp_ok_q,
  input wire logic       rf_rsp_error_q,
  input wire logic       rf_rsp_guard_valid_q,
  input wire logic       ser_valid,
  input wire logic       ser_write,
  input wire logic       upper_area_select,
  input wire logic [3:0] ser_addr,
  input wire logic       ser_pwd_ok,
  input wire logic       ser_rsp_valid_q,
  input wire logic       ser_rsp_error_q
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  sequence s_take;
    rf_cmd_valid && rf_cmd_ready;
  endsequence
  sequence s_slow_answer;
    !rf_rsp_valid_q && !rf_cmd_ready ##1 rf_rsp_valid_q;
  endsequence
  a_quick_answer: assert property (s_take ##0 rf_cmd_code < 3'h4
    |=> rf_rsp_valid_q) else $error("late rf answer");
  a_present_slow: assert property (s_take
    ##0 rf_cmd_code == `RFSP_CMD_PWD_PRESENT ##0 rf_pwd_sel != 2'h0
    |=> s_slow_answer)
    else $error("bad present timing");
  a_guard_flag: assert property (s_take ##0 rf_cmd_code == 3'h0
    |=> !rf_rsp_ok_q || rf_rsp_guard_valid_q == $past(rf_opt_flag))
    else $error("guard flag wrong");
  a_answer_kind: assert property (rf_rsp_valid_q
    |-> rf_rsp_ok_q != rf_rsp_error_q) else $error("bad answer kind");
  a_ser_answer: assert property (ser_valid |=> ser_rsp_valid_q)
    else $error("serial answer missing");
  a_ser_select: assert property (ser_valid && !upper_area_select
    |=> ser_rsp_error_q) else $error("select not refused");
  a_ser_align: assert property (ser_valid && ser_addr[1:0] != 2'h0
    |=> ser_rsp_error_q) else $error("misalign not refused");
  a_ser_locked: assert property (ser_valid && ser_write
    && !ser_pwd_ok |=> ser_rsp_error_q) else $error("write not refused");
endmodule // rfsp_guard_properties
bind rfsp_sector_guard rfsp_guard_properties u_props (.core_clk, .reset_n,
  .rf_cmd_valid, .rf_cmd_ready, .rf_cmd_code, .rf_pwd_sel, .rf_opt_flag,
  .rf_rsp_valid_q,
  .rf_rsp_ok_q, .rf_rsp_error_q, .rf_rsp_guard_valid_q, .ser_valid,
  .ser_write, .upper_area_select, .ser_addr, .ser_pwd_ok, .ser_rsp_valid_q,
  .ser_rsp_error_q);
`default_nettype wire

// file: tb/rfsp_host_model.sv
// rf reader model driving the command port
`default_nettype none
module rfsp_host_model (
  input  wire logic        core_clk,
  input  wire logic        rf_cmd_ready,
  input  wire logic        rf_rsp_valid_q,
  input  wire logic        rf_rsp_error_q,
  output var  logic        rf_cmd_valid,
  output var  logic [2:0]  rf_cmd_code,
  output var  logic [3:0]  rf_sector,
  output var  logic [1:0]  rf_pwd_sel,
  output var  logic [31:0] rf_data,
  output var  logic [3:0]  rf_guard_bits,
  output var  logic        rf_opt_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    rf_cmd_valid = 1'b0;
    {rf_cmd_code, rf_sector, rf_pwd_sel, rf_data, rf_guard_bits} = '0;
    rf_opt_flag = 1'b0;
  end
  // one command; err is unknown when no answer comes
  task automatic cmd(input logic [2:0] c, input logic [3:0] s,
      input logic [1:0] p, input logic [31:0] d, input logic [3:0] b,
      input logic o, output logic err);
    int n;
    @(posedge core_clk);
    #1;
    {rf_cmd_code, rf_sector, rf_pwd_sel, rf_data, rf_guard_bits} =
      {c, s, p, d, b};
    rf_opt_flag = o;
    rf_cmd_valid = 1'b1;
    do @(posedge core_clk); while (!rf_cmd_ready);
    #1;
    rf_cmd_valid = 1'b0;
    rf_data = ~rf_data;
    for (n = 0; n < 3 && !rf_rsp_valid_q; n++) begin
      @(posedge core_clk);
      #1;
    end
    err = rf_rsp_valid_q ? rf_rsp_error_q : 1'bx;
  endtask
endmodule // rfsp_host_model
`default_nettype wire

// file: tb/test_rf_sector_password_protection.sv
// self-checking bench of the sector password protection
`default_nettype none
module test_rf_sector_password_protection;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [3:0] c, s, p;
    logic [7:0] d;
    logic [3:0] b, oe;
  } rfsp_row_t;
  // code, sector, sel, data, bits, {opt, error}
  rfsp_row_t rows [22] = '{28'h0000002, 28'h2100040, 28'h2100001,
    28'h1100001, 28'h3010501, 28'h4010000, 28'h1100000, 28'h3010500,
    28'h4010001, 28'h1100001, 28'h4010500, 28'h5010000, 28'h22000a0,
    28'h0200003, 28'h4020000, 28'h0200002, 28'h5010001, 28'h4000001,
    28'h23000f0, 28'h4030000, 28'h0300000, 28'h1300001};
  rfsp_row_t r;
  logic err;
  int failures = 0, checks_done = 0, cycles = 0;
  logic core_clk = 1'b0, reset_n = 1'b0, ser_valid = 1'b0, ser_write = 1'b0;
  logic upper_area_select = 1'b0, ser_pwd_ok = 1'b0;
  logic [3:0] ser_addr = 4'h0, ser_be = 4'h0;
  logic [31:0] ser_wdata = 32'h0;
  logic rf_cmd_valid, rf_cmd_ready, rf_opt_flag, rf_rsp_valid_q, rf_rsp_ok_q;
  logic rf_rsp_error_q, rf_rsp_guard_valid_q, ser_rsp_valid_q, ser_rsp_error_q;
  logic [2:0] rf_cmd_code;
  logic [3:0] rf_sector, rf_guard_bits;
  logic [1:0] rf_pwd_sel, rf_presented_q;
  logic [7:0] rf_rsp_guard_q;
  logic [31:0] rf_data, rf_rsp_data_q, ser_rdata_q;
  always #5 core_clk = ~core_clk;
  rfsp_sector_guard dut (.core_clk, .reset_n, .rf_cmd_valid, .rf_cmd_ready,
    .rf_cmd_code, .rf_sector, .rf_pwd_sel, .rf_data, .rf_guard_bits,
    .rf_opt_flag, .rf_rsp_valid_q, .rf_rsp_ok_q, .rf_rsp_error_q,
    .rf_rsp_guard_valid_q, .rf_rsp_guard_q, .rf_rsp_data_q, .rf_presented_q,
    .ser_valid, .ser_write, .upper_area_select, .ser_addr, .ser_be,
    .ser_wdata, .ser_pwd_ok, .ser_rsp_valid_q, .ser_rsp_error_q, .ser_rdata_q);
  rfsp_host_model u_host (.core_clk, .rf_cmd_ready, .rf_rsp_valid_q,
    .rf_rsp_error_q, .rf_cmd_valid, .rf_cmd_code, .rf_sector, .rf_pwd_sel,
    .rf_data, .rf_guard_bits, .rf_opt_flag);
  task automatic summarize();
    if (failures == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic cmpw(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic cmp1(input logic g, input logic e);
    cmpw({31'h0, g}, {31'h0, e});
  endtask
  // one serial access and its error answer
  task automatic ser(input logic w, sl, input logic [3:0] a, be,
      input logic [31:0] wd, input logic ok, ee);
    @(posedge core_clk);
    #1;
    {ser_valid, ser_write, upper_area_select} = {1'b1, w, sl};
    {ser_addr, ser_be, ser_wdata, ser_pwd_ok} = {a, be, wd, ok};
    @(posedge core_clk);
    #1;
    ser_valid = 1'b0;
    ser_wdata = ~ser_wdata;
    cmp1(ser_rsp_error_q, ee);
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      summarize();
    end
  end
  initial begin
    repeat (2) @(posedge core_clk);
    #1 reset_n = 1'b1;
    foreach (rows[i]) begin
      r = rows[i];
      u_host.cmd(r.c[2:0], r.s, r.p[1:0], {24'h0, r.d}, r.b, r.oe[1], err);
      cmp1(err, r.oe[0]);
      if (r.c == 4'h0 && !r.oe[0])
        cmp1(rf_rsp_guard_valid_q, r.oe[1]);
    end
    cmpw(rf_rsp_data_q, 32'h00000005);
    cmpw({24'h0, rf_rsp_guard_q}, 32'h0000001f);
    ser(1'b0, 1'b1, 4'h0, 4'h0, 32'h0, 1'b0, 1'b0);
    cmpw(ser_rdata_q, 32'h1f150900);
    ser(1'b0, 1'b0, 4'h4, 4'h0, 32'h0, 1'b0, 1'b1);
    ser(1'b0, 1'b1, 4'h2, 4'h0, 32'h0, 1'b0, 1'b1);
    ser(1'b1, 1'b1, 4'h0, 4'h2, 32'h0, 1'b0, 1'b1);
    ser(1'b1, 1'b1, 4'h0, 4'h2, 32'h0, 1'b1, 1'b0);
    u_host.cmd(3'h2, 4'h1, 2'h0, 32'h0, 4'h0, 1'b0, err);
    cmp1(err, 1'b0);
    reset_n = 1'b0;
    repeat (2) @(posedge core_clk);
    #1 reset_n = 1'b1;
    cmpw({30'h0, rf_presented_q}, 32'h0);
    u_host.cmd(3'h1, 4'h2, 2'h0, 32'h0, 4'h0, 1'b0, err);
    cmp1(err, 1'b0);
    u_host.cmd(3'h4, 4'h0, 2'h1, 32'h0, 4'h0, 1'b0, err);
    cmp1(err, 1'b0);
    summarize();
  end
endmodule // test_rf_sector_password_protection
`default_nettype wire
